//--- slcm_pkg.sv
package slcm_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;     // core clock, 50 MHz
    localparam int SCL_PERIOD_NS = 10000;  // standard-mode serial clock, 100 kbit/s
    // one serial bit is split into four equal quarters
    localparam int QUARTER_CYC   = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam logic [6:0] QCNT_MAX   = 7'(QUARTER_CYC - 1);
    // edges after reset release before the synchronised straps are trusted
    localparam logic [1:0] LATCH_WAIT = 2'h3;

    // ****************************************************************
    // strap pin vector layout
    // ****************************************************************
    localparam int STRAP_W = 10;
    localparam int SB_FIX0 = 0;  // also carries the suspend indicator
    localparam int SB_FIX1 = 1;
    localparam int SB_CHG  = 2;  // two bits, ports 1..2
    localparam int SB_MOFF = 4;  // two bits
    localparam int SB_POFF = 6;  // two bits
    localparam int SB_SEL0 = 8;
    localparam int SB_SEL1 = 9;

    // ****************************************************************
    // eeprom load
    // ****************************************************************
    localparam logic [6:0] EEPROM_ADDR = 7'h50;
    localparam logic [7:0] BOOT_REG    = 8'h00;
    localparam logic [7:0] BOOT_LEN    = 8'h01;
    // layout of the configuration byte read at boot
    localparam int CB_FIX  = 0;  // two bits, fixed-port mask
    localparam int CB_SUSP = 2;  // suspend indicator active low
    localparam int CB_CHG  = 3;  // two bits
    localparam int CB_OFF  = 5;  // two bits

    typedef enum logic [1:0] {OP_START, OP_STOP, OP_BYTE} slcm_op_t;

    typedef struct packed {
        logic       go;
        slcm_op_t   op;
        logic [7:0] data;
        logic       rx;    // receive a byte instead of sending
        logic       mack;  // master drives acknowledge after a received byte
    } slcm_req_t;

    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
        logic       nack;       // slave did not acknowledge
        logic       sda_level;  // synchronised data line
    } slcm_rsp_t;

    typedef struct packed {
        logic [1:0] fixed;
        logic       susp_low;
        logic [1:0] charge;
        logic [1:0] lines_off;
    } slcm_cfg_t;

    // two-bit fixed-port strap to a per-port mask
    function automatic logic [1:0] decode_fixed(input logic [1:0] s);
        case (s)
            2'h0:    decode_fixed = 2'h0;
            2'h1:    decode_fixed = 2'h1;
            default: decode_fixed = 2'h3;
        endcase
    endfunction : decode_fixed

endpackage : slcm_pkg

//--- slcm_bit_engine.sv
`timescale 1ns/1ps
module slcm_bit_engine
    import slcm_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  slcm_req_t      req,
    output slcm_rsp_t      rsp,
    input  wire logic      sda_in,
    output wire logic      sda_out,
    output wire logic      sda_oe,
    output wire logic      scl_out,
    output wire logic      scl_oe
);

    typedef enum {E_IDLE, E_RUN} slcm_est_t;

    typedef struct packed {
        slcm_est_t  st;
        slcm_op_t   op;
        logic [1:0] qtr;
        logic [6:0] cnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic       rx;
        logic       mack;
        logic       scl_oe;
        logic       sda_oe;
        logic       done;
        logic       nack;
        logic       s1;
        logic       s2;
    } slcm_eng_t;

    slcm_eng_t q, d;

    // ****************************************************************
    // quarter-bit sequencer
    // ****************************************************************
    always_comb begin
        d      = q;
        d.done = 1'b0;
        d.s1   = sda_in;   // first stage seen only by s2
        d.s2   = q.s1;
        case (q.st)
            E_IDLE: begin
                if (req.go) begin
                    d.st   = E_RUN;
                    d.op   = req.op;
                    d.sh   = req.data;
                    d.rx   = req.rx;
                    d.mack = req.mack;
                    d.qtr  = 2'h0;
                    d.cnt  = 7'h00;
                    d.bitn = 4'h0;
                    d.nack = 1'b0;
                end
            end
            E_RUN: begin
                d.cnt = q.cnt + 7'h01;
                if (q.cnt == QCNT_MAX) begin
                    d.cnt = 7'h00;
                    d.qtr = q.qtr + 2'h1;
                    case (q.op)
                        // release data, raise clock, pull data low, pull clock low
                        OP_START: begin
                            case (q.qtr)
                                2'h0:    d.sda_oe = 1'b0;
                                2'h1:    d.scl_oe = 1'b0;
                                2'h2:    d.sda_oe = 1'b1;
                                default: begin
                                    d.scl_oe = 1'b1;
                                    d.done   = 1'b1;
                                    d.st     = E_IDLE;
                                end
                            endcase
                        end
                        // data low under low clock, raise clock, then release data
                        OP_STOP: begin
                            case (q.qtr)
                                2'h0: begin
                                    d.scl_oe = 1'b1;
                                    d.sda_oe = 1'b1;
                                end
                                2'h1:    d.scl_oe = 1'b0;
                                2'h2:    d.sda_oe = 1'b0;
                                default: begin
                                    d.done = 1'b1;
                                    d.st   = E_IDLE;
                                end
                            endcase
                        end
                        default: begin
                            case (q.qtr)
                                2'h0: begin
                                    // data changes only while the clock is low
                                    if (q.bitn < 4'h8)
                                        d.sda_oe = q.rx ? 1'b0 : ~q.sh[7];
                                    else
                                        d.sda_oe = q.rx ? q.mack : 1'b0;
                                end
                                2'h1: d.scl_oe = 1'b0;
                                2'h2: begin
                                    if (q.bitn < 4'h8)
                                        d.sh = {q.sh[6:0], q.s2};
                                    else
                                        d.nack = q.s2;
                                end
                                default: begin
                                    d.scl_oe = 1'b1;
                                    d.bitn   = q.bitn + 4'h1;
                                    if (q.bitn == 4'h8) begin
                                        d.done = 1'b1;
                                        d.st   = E_IDLE;
                                    end
                                end
                            endcase
                        end
                    endcase
                end
            end
            default: d.st = E_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: E_IDLE, op: OP_START, default: '0};
        end else begin
            q <= d;
        end
    end

    // open-drain lines: only ever pulled low
    assign sda_out       = 1'b0;
    assign scl_out       = 1'b0;
    assign sda_oe        = q.sda_oe;
    assign scl_oe        = q.scl_oe;
    assign rsp.done      = q.done;
    assign rsp.rdata     = q.sh;
    assign rsp.nack      = q.nack;
    assign rsp.sda_level = q.s2;

endmodule : slcm_bit_engine

//--- slcm_strap_loader.sv
`timescale 1ns/1ps
// Notes on behaviour
// - straps float during reset, sampled at release and held as defaults
// - after latching, shared strap pins are driven as normal outputs
// - fixed-port strap: 0 none, 1 port 1, 2 or 3 both ports
// - strap bit 0 low gives active-high suspend indicator, high gives active-low
// - with local power detect, port fixedness comes only from internal settings
// - high charge strap makes that port advertise charging, low does not
// - port lines off only when both minus and plus off straps are high
// - serial master runs 100 kbit/s standard mode, 7-bit address, no extensions
// - master makes the clock, start and stop, and picks transfer direction
// - write: address, register byte, then data; register advances per acked byte
// - a sequential write ends with a stop
// - reads first set the register with a write phase; each byte advances it
// - every read byte acknowledged except the last, which gets a not-acknowledge
// - write phase ended by stop gives a fresh start, else a repeated start
// - data line high and both select straps high: load from eeprom, ignore straps
module slcm_strap_loader
    import slcm_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    // shared strap pins
    input  wire logic [STRAP_W-1:0] strap_in,
    output logic      [STRAP_W-1:0] strap_out,
    output logic      [STRAP_W-1:0] strap_oe,
    input  wire logic [STRAP_W-1:0] func_out,
    input  wire logic               suspend_req,
    output logic                    suspend_indicator_out,
    // port feature results
    input  wire logic               local_power_detect,
    input  wire logic [1:0]         local_fixed_port,
    output logic      [1:0]         port_fixed,
    output logic                    suspend_active_low,
    output logic      [1:0]         charge_enable,
    output logic      [1:0]         port_lines_off,
    output logic                    straps_latched,
    output logic                    eeprom_mode,
    output logic                    load_done,
    // command port
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic               cmd_write,
    input  wire logic [7:0]         cmd_reg,
    input  wire logic [7:0]         cmd_len,
    input  wire logic               cmd_stop_between,
    input  wire logic               wr_valid,
    input  wire logic [7:0]         wr_data,
    output logic                    wr_ready,
    output logic                    rd_valid,
    output logic      [7:0]         rd_data,
    output logic      [7:0]         rd_reg,
    output logic                    busy,
    output logic                    nack_err,
    // two-wire link
    input  wire logic               sda_in,
    output wire logic               sda_out,
    output wire logic               sda_oe,
    output wire logic               scl_out,
    output wire logic               scl_oe
);

    typedef enum {M_WAIT, M_IDLE, M_START, M_ADDR_W, M_REG, M_WDATA, M_MID_STOP,
                  M_RSTART, M_ADDR_R, M_RDATA, M_STOP} slcm_mst_t;

    typedef struct packed {
        slcm_mst_t          st;
        logic [1:0]         wait_cnt;
        logic [STRAP_W-1:0] s1;
        logic [STRAP_W-1:0] s2;
        logic               lp1;
        logic               lp2;
        logic               latched;
        logic               boot;
        logic               eeprom;
        slcm_cfg_t          cfg;
        logic [1:0]         fixed_out;
        logic [STRAP_W-1:0] pin_out;
        logic               susp_out;
        logic               pend;
        logic               write;
        logic               stop_mid;
        logic [7:0]         reg_addr;
        logic [7:0]         len;
        logic               rd_valid;
        logic [7:0]         rd_data;
        logic [7:0]         rd_reg;
        logic               nack_err;
        logic               load_done;
    } slcm_top_t;

    slcm_top_t q, d;
    slcm_req_t req;
    slcm_rsp_t rsp;
    logic      taking;

    // ****************************************************************
    // strap capture, pin drive and transaction sequencer
    // ****************************************************************
    always_comb begin
        d          = q;
        d.rd_valid = 1'b0;
        d.s1       = strap_in;
        d.s2       = q.s1;
        d.lp1      = local_power_detect;
        d.lp2      = q.lp1;
        req        = '{go: 1'b0, op: OP_START, default: '0};
        taking     = 1'b0;
        // local power detect overrides the fixed-port straps
        d.fixed_out = q.lp2 ? local_fixed_port : q.cfg.fixed;
        // indicator level follows the latched polarity
        d.susp_out  = suspend_req ^ q.cfg.susp_low;
        d.pin_out   = func_out;
        d.pin_out[SB_FIX0] = d.susp_out;
        case (q.st)
            M_WAIT: begin
                // pins are released here; sample once the synchronisers have settled
                d.wait_cnt = q.wait_cnt + 2'h1;
                if (q.wait_cnt == LATCH_WAIT) begin
                    d.latched = 1'b1;
                    if (rsp.sda_level && q.s2[SB_SEL0] && q.s2[SB_SEL1]) begin
                        // eeprom decides; straps other than select are ignored
                        d.eeprom   = 1'b1;
                        d.boot     = 1'b1;
                        d.write    = 1'b0;
                        d.stop_mid = 1'b0;
                        d.reg_addr = BOOT_REG;
                        d.len      = BOOT_LEN;
                        d.st       = M_START;
                    end else begin
                        d.cfg.fixed     = decode_fixed(q.s2[SB_FIX1:SB_FIX0]);
                        d.cfg.susp_low  = q.s2[SB_FIX0];
                        d.cfg.charge    = q.s2[SB_CHG+1:SB_CHG];
                        d.cfg.lines_off = q.s2[SB_MOFF+1:SB_MOFF]
                                        & q.s2[SB_POFF+1:SB_POFF];
                        d.st            = M_IDLE;
                    end
                end
            end
            M_IDLE: begin
                if (cmd_valid) begin
                    d.write    = cmd_write;
                    d.stop_mid = cmd_stop_between;
                    d.reg_addr = cmd_reg;
                    d.len      = cmd_len;
                    d.nack_err = 1'b0;
                    d.st       = M_START;
                end
            end
            M_START, M_RSTART: begin
                req.op = OP_START;
                req.go = ~q.pend;
                if (rsp.done)
                    d.st = (q.st == M_START) ? M_ADDR_W : M_ADDR_R;
            end
            M_ADDR_W, M_REG, M_ADDR_R: begin
                // direction bit chosen by the master for each phase
                req.op   = OP_BYTE;
                req.go   = ~q.pend;
                req.data = (q.st == M_REG)    ? q.reg_addr :
                           (q.st == M_ADDR_W) ? {EEPROM_ADDR, 1'b0}
                                              : {EEPROM_ADDR, 1'b1};
                if (rsp.done) begin
                    if (rsp.nack) begin
                        d.nack_err = 1'b1;
                        d.st       = M_STOP;
                    end else if (q.st == M_ADDR_W) begin
                        d.st = M_REG;
                    end else if (q.st == M_REG) begin
                        // read transfers set the register with this write phase
                        d.st = q.write    ? M_WDATA :
                               q.stop_mid ? M_MID_STOP : M_RSTART;
                    end else begin
                        d.st = (q.len == 8'h00) ? M_STOP : M_RDATA;
                    end
                end
            end
            M_WDATA: begin
                req.op   = OP_BYTE;
                req.data = wr_data;
                if (q.len == 8'h00) begin
                    d.st = M_STOP;
                end else if (!q.pend && wr_valid) begin
                    req.go = 1'b1;
                    taking = 1'b1;
                end
                if (rsp.done) begin
                    if (rsp.nack) begin
                        d.nack_err = 1'b1;
                        d.st       = M_STOP;
                    end else begin
                        d.reg_addr = q.reg_addr + 8'h01;
                        d.len      = q.len - 8'h01;
                    end
                end
            end
            M_MID_STOP: begin
                // stop closes the address phase; a fresh start follows
                req.op = OP_STOP;
                req.go = ~q.pend;
                if (rsp.done)
                    d.st = M_RSTART;
            end
            M_RDATA: begin
                req.op   = OP_BYTE;
                req.rx   = 1'b1;
                req.mack = (q.len != 8'h01);
                req.go   = ~q.pend;
                if (rsp.done) begin
                    d.rd_valid = 1'b1;
                    d.rd_data  = rsp.rdata;
                    d.rd_reg   = q.reg_addr;
                    if (q.boot && q.reg_addr == BOOT_REG) begin
                        d.cfg.fixed     = rsp.rdata[CB_FIX+1:CB_FIX];
                        d.cfg.susp_low  = rsp.rdata[CB_SUSP];
                        d.cfg.charge    = rsp.rdata[CB_CHG+1:CB_CHG];
                        d.cfg.lines_off = rsp.rdata[CB_OFF+1:CB_OFF];
                    end
                    d.reg_addr = q.reg_addr + 8'h01;
                    d.len      = q.len - 8'h01;
                    if (q.len == 8'h01)
                        d.st = M_STOP;
                end
            end
            M_STOP: begin
                req.op = OP_STOP;
                req.go = ~q.pend;
                if (rsp.done) begin
                    d.st = M_IDLE;
                    if (q.boot) begin
                        d.boot      = 1'b0;
                        d.load_done = 1'b1;
                    end
                end
            end
            default: d.st = M_IDLE;
        endcase
        // one engine operation in flight at a time
        if (req.go)
            d.pend = 1'b1;
        if (rsp.done)
            d.pend = 1'b0;
    end

    // reset loads constants only; strap values arrive through the sampler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: M_WAIT, cfg: '0, default: '0};
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // serial bit engine
    // ****************************************************************
    slcm_bit_engine u_engine (
        .clk     (clk),
        .rst_n   (rst_n),
        .req     (req),
        .rsp     (rsp),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .scl_out (scl_out),
        .scl_oe  (scl_oe)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    // pins float until latched, then drive; after that cfg changes only when the eeprom boot byte is read
    assign strap_oe              = {STRAP_W{q.latched}};
    assign strap_out             = q.pin_out;
    assign suspend_indicator_out = q.susp_out;
    assign port_fixed            = q.fixed_out;
    assign suspend_active_low    = q.cfg.susp_low;
    assign charge_enable         = q.cfg.charge;
    assign port_lines_off        = q.cfg.lines_off;
    assign straps_latched        = q.latched;
    assign eeprom_mode           = q.eeprom;
    assign load_done             = q.load_done;
    assign cmd_ready             = (q.st == M_IDLE);
    assign wr_ready              = taking;
    assign rd_valid              = q.rd_valid;
    assign rd_data               = q.rd_data;
    assign rd_reg                = q.rd_reg;
    assign busy                  = (q.st != M_IDLE);
    assign nack_err              = q.nack_err;

endmodule : slcm_strap_loader

//--- slcm_sva.sv
`timescale 1ns/1ps
module slcm_sva
    import slcm_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic [STRAP_W-1:0] strap_oe,
    input wire logic               straps_latched,
    input wire logic [1:0]         charge_enable,
    input wire logic [1:0]         port_lines_off,
    input wire logic               eeprom_mode,
    input wire logic               local_power_detect,
    input wire logic [1:0]         local_fixed_port,
    input wire logic [1:0]         port_fixed,
    input wire logic               busy,
    input wire logic               rd_valid,
    input wire logic               sda_oe,
    input wire logic               scl_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // pin drive follows the latch, never before it
    oe_reset_a: assert property (!straps_latched |-> strap_oe == '0)
        else $error("strap pin driven early");
    oe_latched_a: assert property (straps_latched |=> straps_latched && strap_oe == '1)
        else $error("strap pin not driven");
    cfg_hold_a: assert property (straps_latched && $past(straps_latched) && !eeprom_mode
        |-> $stable({charge_enable, port_lines_off})) else $error("latched config moved");
    // sync delay is two flops plus the output register, so five cycles is ample
    fixed_local_a: assert property ((straps_latched && local_power_detect
        && $stable(local_fixed_port))[*5] |-> port_fixed == local_fixed_port)
        else $error("fixed mask ignores local setting");
    bus_idle_a: assert property (!busy |-> !scl_oe && !sda_oe)
        else $error("bus held while idle");
    rd_pulse_a: assert property (rd_valid |=> !rd_valid)
        else $error("read strobe too long");
    scl_high_a: assert property ($fell(scl_oe) |=> !scl_oe [*8])
        else $error("serial clock high too short");
    scl_low_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
        else $error("serial clock low too short");
endmodule : slcm_sva
bind slcm_strap_loader slcm_sva u_sva (.*);

//--- slcm_eeprom_model.sv
`timescale 1ns/1ps
module slcm_eeprom_model
    import slcm_pkg::*;
(
    input  wire logic scl,
    input  wire logic sda,
    output logic      pull
);
    logic [7:0] mem [256];
    logic [7:0] ptr = 8'h00, sh = 8'h00;
    logic       act = 1'b0, adr = 1'b0, rd = 1'b0, regp = 1'b0, mute = 1'b0;
    int         n = 0;
    initial pull = 1'b0;
    // start and repeated start look alike; count from minus one so bit 7 lands at zero
    always @(negedge sda) if (scl) begin act = 1; adr = 1; rd = 0; n = -1; end
    always @(posedge sda) if (scl) begin act = 0; pull = 0; end
    // a released line in the ack slot of a read ends our driving
    always @(posedge scl) if (act) begin
        if (n == 8) act = !(rd && sda);
        else if (!rd) sh = {sh[6:0], sda};
    end
    // drive only while the clock is low, so no false start or stop
    always @(negedge scl) if (act) begin
        n = n + 1;
        pull = 0;
        if (n == 8 && adr) begin
            pull = sh[7:1] == EEPROM_ADDR && !mute;
            rd = sh[0];
            regp = !sh[0];
            adr = 0;
        end
        else if (n == 8 && !rd) begin
            pull = 1;
            if (!regp) mem[ptr] = sh;
            ptr = regp ? sh : ptr + 8'h01;
            regp = 0;
        end
        else if (n == 9) begin
            n = 0;
            if (rd) sh = mem[ptr];
            if (rd) ptr = ptr + 8'h01;
        end
        if (rd && n < 8) pull = !sh[7-n];
    end
endmodule : slcm_eeprom_model

//--- tb.sv
`timescale 1ns/1ps
module tb
    import slcm_pkg::*;
;
    logic clk, rst_n, suspend_req, local_power_detect, cmd_valid, cmd_write, cmd_stop_between;
    logic wr_valid, cmd_ready, wr_ready, rd_valid, busy, nack_err, sda_oe, scl_oe, pull;
    logic straps_latched, eeprom_mode, load_done, suspend_indicator_out, suspend_active_low;
    logic [STRAP_W-1:0] strap_in, strap_oe, func_out, strap_out;
    logic [1:0]         local_fixed_port, port_fixed, charge_enable, port_lines_off;
    logic [7:0]         cmd_reg, cmd_len, wr_data, rd_data, rd_reg;
    logic [7:0]         rq[$];
    int                 failures, compares, i, wr_n;
    wire                scl = !scl_oe;
    wire                sda = !(sda_oe | pull);
    slcm_strap_loader dut (.*, .sda_in(sda), .sda_out(), .scl_out());
    slcm_eeprom_model m (.scl(scl), .sda(sda), .pull(pull));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // collect read bytes and count taken write bytes mid-cycle, where both are settled
    always @(negedge clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (wr_ready === 1'b1) wr_n++;
    end
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic boot(input logic [9:0] s);
        rst_n = 0;
        strap_in = s;
        repeat (2) @(negedge clk);
        chk("strap_oe", 10'h000, strap_oe);
        rst_n = 1;
        repeat (6) @(negedge clk);
    endtask : boot
    // request held until the edge that takes it, then wait out the transfer
    task automatic cmd(input logic w, input logic [7:0] r, input logic [7:0] l, input logic sb);
        int k;
        {cmd_write, cmd_reg, cmd_len, cmd_stop_between, cmd_valid} = {w, r, l, sb, 1'b1};
        for (k = 0; k < 99 && cmd_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
        for (k = 0; k < 40000 && busy !== 1'b0; k++) @(negedge clk);
        chk("busy", 10'h000, busy);
    endtask : cmd
    task automatic close_out();
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        {rst_n, suspend_req, local_power_detect, local_fixed_port, cmd_valid} = '0;
        {cmd_write, cmd_reg, cmd_len, cmd_stop_between, strap_in} = '0;
        {wr_valid, wr_data} = {1'b1, 8'h3C};
        func_out = 10'h2A6;
        {m.mem[8'h11], m.mem[8'h00]} = {8'h77, 8'h5A};
        @(negedge clk);
        for (i = 0; i < 4; i++) begin
            boot({2'h0, 2'h2, 2'(i), 2'(i), 2'(i)});
            chk("port_fixed", 10'((i == 0) ? 0 : (i == 1) ? 1 : 3), port_fixed);
            chk("susp_low", 10'(i & 1), suspend_active_low);
            chk("charge", 10'(i), charge_enable);
            chk("lines_off", 10'(i & 2), port_lines_off);
            chk("strap_oe", 10'h3FF, strap_oe);
            chk("latched", 10'h001, straps_latched);
            strap_in = ~strap_in;
            suspend_req = 1;
            repeat (3) @(negedge clk);
            chk("charge_held", 10'(i), charge_enable);
            chk("susp_out", 10'((i & 1) ^ 1), suspend_indicator_out);
            chk("strap_out", 10'h2A6 | 10'((i & 1) ^ 1), strap_out);
            suspend_req = 0;
        end
        {local_power_detect, local_fixed_port} = 3'h6;
        repeat (6) @(negedge clk);
        chk("local_fixed", 10'h002, port_fixed);
        local_power_detect = 0;
        cmd(1, 8'h10, 8'h01, 0);
        chk("wr_mem", 10'h03C, m.mem[8'h10]);
        cmd(0, 8'h10, 8'h02, 1);
        cmd(0, 8'h11, 8'h01, 0);
        chk("rd0", 10'h03C, rq[0]);
        chk("rd1", 10'h077, rq[1]);
        chk("rd2", 10'h077, rq[2]);
        chk("rd_reg", 10'h011, rd_reg);
        chk("nack", 10'h000, nack_err);
        // a refused address must stop the write before any data byte is taken
        m.mute = 1;
        cmd(1, 8'h20, 8'h01, 0);
        m.mute = 0;
        chk("nack_err", 10'h001, nack_err);
        chk("wr_taken", 10'h001, 10'(wr_n));
        boot(10'h300);
        for (i = 0; i < 30000 && load_done !== 1'b1; i++) @(negedge clk);
        chk("load_done", 10'h001, load_done);
        chk("ee_mode", 10'h001, eeprom_mode);
        chk("ee_charge", 10'h003, charge_enable);
        chk("ee_off", 10'h002, port_lines_off);
        close_out();
    end
    // about 85k cycles of traffic expected
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule : tb
